/* rtl/cabx_pkg.sv */
// Constants, encodings and carrier types for the ALU and bit instruction execute block.
// Assumes a single 20 MHz core clock and a fetch stage on the same clock.
package cabx_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int INSTR_W = 14;
	localparam int PC_W    = 13;
	localparam int PORT_W  = 6;
	localparam int BUS_AW  = 8;

	// ----------------------------------------------------------------
	// Opcode fields
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_XOR_LITERAL   = 6'h3A;
	localparam logic [5:0] OP_AND_LITERAL   = 6'h39;
	localparam logic [4:0] OP_ADD_LITERAL   = 5'h1F;
	localparam logic [5:0] OP_ADD_W_TO_FILE = 6'h07;
	localparam logic [3:0] OP_BIT_CLEAR     = 4'h4;
	localparam logic [3:0] OP_BIT_SET       = 4'h5;

	// ----------------------------------------------------------------
	// Special file addresses and status bits
	// ----------------------------------------------------------------
	localparam logic [6:0] FA_TIMER0_COUNT = 7'h01;
	localparam logic [6:0] FA_PC_LOW       = 7'h02;
	localparam logic [6:0] FA_STATUS       = 7'h03;
	localparam logic [6:0] FA_PORT_A       = 7'h05;
	localparam int         ST_C            = 0;
	localparam int         ST_DC           = 1;
	localparam int         ST_Z            = 2;

	// ----------------------------------------------------------------
	// Software port map and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  BA_W        = 8'h80;
	localparam logic [7:0]  BA_CTRL     = 8'h81;
	localparam logic [7:0]  BA_PC_LO    = 8'h82;
	localparam logic [7:0]  BA_PC_HI    = 8'h83;
	localparam int          CTRL_PSA_T0 = 0;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [7:0]  W_RESET     = 8'h00;
	localparam logic [7:0]  STAT_RESET  = 8'h00;
	localparam logic [12:0] PC_RESET    = 13'h0000;
	localparam logic [5:0]  LATCH_RESET = 6'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ALU_NONE, ALU_XOR, ALU_AND, ALU_ADD, ALU_BCLR, ALU_BSET
	} cabx_alu_op_t;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} cabx_flags_t;

	typedef struct packed {
		cabx_alu_op_t op;
		logic         lit;
		logic         to_file;
		logic [2:0]   bit_sel;
		logic [6:0]   faddr;
		logic [7:0]   literal;
	} cabx_decode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cabx_bus_req_t;

endpackage

/* rtl/cabx_alu.sv */
// Combinational ALU for the execute block: logic, add and single-bit edits.
// Assumes operands settle within one core clock cycle.
`timescale 1ns/1ps
module cabx_alu (
	// Operation
	input  wire cabx_pkg::cabx_alu_op_t op,
	input  wire logic [7:0]             a,
	input  wire logic [7:0]             b,
	input  wire logic [2:0]             bit_sel,
	// Result
	output logic [7:0]                  result,
	output cabx_pkg::cabx_flags_t       flags,
	output cabx_pkg::cabx_flags_t       upd
);
	import cabx_pkg::*;

	logic [4:0] low_sum;
	logic [8:0] full_sum;

	// ----------------------------------------------------------------
	// Adder
	// ----------------------------------------------------------------
	assign low_sum  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
	assign full_sum = {1'b0, a} + {1'b0, b};

	// ----------------------------------------------------------------
	// Operation select
	// ----------------------------------------------------------------
	always_comb begin
		result = b;
		upd    = '0;
		case (op)
			ALU_XOR: begin
				result = a ^ b;
				upd.z  = 1'b1;
			end
			ALU_AND: begin
				result = a & b;
				upd.z  = 1'b1;
			end
			ALU_ADD: begin
				result = full_sum[7:0];
				upd    = '1;
			end
			ALU_BCLR: result = b & ~(8'h01 << bit_sel);
			ALU_BSET: result = b | (8'h01 << bit_sel);
			default:  result = b;
		endcase
	end

	assign flags.z  = (result == 8'h00);
	assign flags.c  = full_sum[8];
	assign flags.dc = low_sum[4];

endmodule // cabx_alu

/* rtl/cabx_exec.sv */
// Execute stage for literal logic, add and bit edit instructions of an 8-bit core.
// Assumes instructions arrive from a fetch stage on SYS_CLK and port pins are asynchronous.
`timescale 1ns/1ps
module cabx_exec (
	// Clock and reset
	input  wire logic                  SYS_CLK,
	input  wire logic                  RST_N,
	// Instruction stream
	input  wire logic [13:0]           INSTR,
	input  wire logic                  INSTR_VALID,
	output logic                       INSTR_READY,
	// Software port
	input  wire cabx_pkg::cabx_bus_req_t BUS_REQ,
	output logic [7:0]                 BUS_RDATA,
	// Port pins
	input  wire logic [5:0]            PORT_PINS,
	output logic [5:0]                 PORT_OUT,
	// Core state
	output logic                       PRESCALER_CLEAR,
	output logic [12:0]                PROGRAM_COUNTER,
	output logic [7:0]                 W_REG,
	output logic [7:0]                 STATUS_FLAGS
);
	import cabx_pkg::*;

	typedef enum logic {CABX_EXEC, CABX_NOP} cabx_state_t;

	// ----------------------------------------------------------------
	// Storage and wires
	// ----------------------------------------------------------------
	logic [7:0]   file_mem [0:127];
	logic [5:0]   pin_meta;
	logic [5:0]   pin_sync;
	logic [7:0]   ctrl;
	cabx_state_t  state;
	cabx_decode_t dec;
	logic         take;
	logic [7:0]   operand;
	logic [7:0]   result;
	cabx_flags_t  flags;
	cabx_flags_t  upd;
	logic         file_wr;
	logic         w_wr;
	logic         pc_wr;
	logic         bus_file_wr;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_meta <= LATCH_RESET;
			pin_sync <= LATCH_RESET;
		end else begin
			pin_meta <= PORT_PINS;
			pin_sync <= pin_meta;
		end
	end

	// Port and status reads never come from the array: the port reads the synchronised pins
	function automatic logic [7:0] read_file(input logic [6:0] fa);
		if (fa == FA_PORT_A)
			return {2'b00, pin_sync};
		else if (fa == FA_STATUS)
			return STATUS_FLAGS;
		else if (fa == FA_PC_LOW)
			return PROGRAM_COUNTER[7:0];
		else
			return file_mem[fa];
	endfunction

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		dec         = '0;
		dec.op      = ALU_NONE;
		dec.literal = INSTR[7:0];
		dec.faddr   = INSTR[6:0];
		dec.bit_sel = INSTR[9:7];
		if (INSTR[13:8] == OP_XOR_LITERAL) begin
			dec.op  = ALU_XOR;
			dec.lit = 1'b1;
		end else if (INSTR[13:8] == OP_AND_LITERAL) begin
			dec.op  = ALU_AND;
			dec.lit = 1'b1;
		end else if (INSTR[13:9] == OP_ADD_LITERAL) begin
			dec.op  = ALU_ADD;
			dec.lit = 1'b1;
		end else if (INSTR[13:8] == OP_ADD_W_TO_FILE) begin
			dec.op      = ALU_ADD;
			dec.to_file = INSTR[7];
		end else if (INSTR[13:10] == OP_BIT_CLEAR) begin
			dec.op      = ALU_BCLR;
			dec.to_file = 1'b1;
		end else if (INSTR[13:10] == OP_BIT_SET) begin
			dec.op      = ALU_BSET;
			dec.to_file = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Execute
	// ----------------------------------------------------------------
	assign INSTR_READY = (state == CABX_EXEC);
	assign take        = INSTR_VALID && INSTR_READY;
	// Procedural so a file, pin or status change seen inside the function re-evaluates it
	always_comb begin
		operand = dec.lit ? dec.literal : read_file(dec.faddr);
	end
	assign file_wr     = take && dec.to_file && (dec.op != ALU_NONE);
	assign w_wr        = take && !dec.to_file && (dec.op != ALU_NONE);
	assign pc_wr       = file_wr && (dec.faddr == FA_PC_LOW);
	assign bus_file_wr = BUS_REQ.wr && !BUS_REQ.addr[7];

	cabx_alu u_alu (
		.op      (dec.op),
		.a       (W_REG),
		.b       (operand),
		.bit_sel (dec.bit_sel),
		.result  (result),
		.flags   (flags),
		.upd     (upd)
	);

	// Two-cycle sequencing on a program counter low write; the second cycle takes no instruction
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			state <= CABX_EXEC;
		else begin
			case (state)
				CABX_EXEC: if (pc_wr) state <= CABX_NOP;
				CABX_NOP:  state <= CABX_EXEC;
				default:   state <= CABX_EXEC;
			endcase
		end
	end

	// Program counter: steps per instruction, low byte loaded on file write
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			PROGRAM_COUNTER <= PC_RESET;
		else if (pc_wr)
			PROGRAM_COUNTER <= {PROGRAM_COUNTER[12:8], result};
		else if (take)
			PROGRAM_COUNTER <= PROGRAM_COUNTER + 13'h0001;
		else if (BUS_REQ.wr && BUS_REQ.addr == BA_PC_LO)
			PROGRAM_COUNTER <= {PROGRAM_COUNTER[12:8], BUS_REQ.wdata};
		else if (BUS_REQ.wr && BUS_REQ.addr == BA_PC_HI)
			PROGRAM_COUNTER <= {BUS_REQ.wdata[4:0], PROGRAM_COUNTER[7:0]};
	end

	// Working register; instruction writes win over software writes
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			W_REG <= W_RESET;
		else if (w_wr)
			W_REG <= result;
		else if (BUS_REQ.wr && BUS_REQ.addr == BA_W)
			W_REG <= BUS_REQ.wdata;
	end

	// Status: a plain write lands first, then flag updates override their bits
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			STATUS_FLAGS <= STAT_RESET;
		else begin
			if (file_wr && dec.faddr == FA_STATUS)
				STATUS_FLAGS <= result;
			else if (bus_file_wr && BUS_REQ.addr[6:0] == FA_STATUS)
				STATUS_FLAGS <= BUS_REQ.wdata;
			if (take && upd.z)
				STATUS_FLAGS[ST_Z] <= flags.z;
			if (take && upd.c)
				STATUS_FLAGS[ST_C] <= flags.c;
			if (take && upd.dc)
				STATUS_FLAGS[ST_DC] <= flags.dc;
		end
	end

	// Port output latch; a rewrite copies pin levels into it
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			PORT_OUT <= LATCH_RESET;
		else if (file_wr && dec.faddr == FA_PORT_A)
			PORT_OUT <= result[5:0];
		else if (bus_file_wr && BUS_REQ.addr[6:0] == FA_PORT_A)
			PORT_OUT <= BUS_REQ.wdata[5:0];
	end

	// Control: prescaler ownership
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			ctrl <= CTRL_RESET;
		else if (BUS_REQ.wr && BUS_REQ.addr == BA_CTRL)
			ctrl <= BUS_REQ.wdata;
	end

	// Prescaler clear pulse, one cycle after the timer write
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			PRESCALER_CLEAR <= 1'b0;
		else
			PRESCALER_CLEAR <= file_wr && (dec.faddr == FA_TIMER0_COUNT)
			                   && ctrl[CTRL_PSA_T0];
	end

	// ----------------------------------------------------------------
	// File array
	// ----------------------------------------------------------------
	// No reset on the array: contents are undefined after power-up, as in the core
	always_ff @(posedge SYS_CLK) begin
		if (bus_file_wr)
			file_mem[BUS_REQ.addr[6:0]] <= BUS_REQ.wdata;
		if (file_wr)
			file_mem[dec.faddr] <= result;
	end

	// ----------------------------------------------------------------
	// Software read port
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			BUS_RDATA <= 8'h00;
		else if (BUS_REQ.rd) begin
			if (!BUS_REQ.addr[7])
				BUS_RDATA <= read_file(BUS_REQ.addr[6:0]);
			else begin
				case (BUS_REQ.addr)
					BA_W:     BUS_RDATA <= W_REG;
					BA_CTRL:  BUS_RDATA <= ctrl;
					BA_PC_LO: BUS_RDATA <= PROGRAM_COUNTER[7:0];
					BA_PC_HI: BUS_RDATA <= {3'b000, PROGRAM_COUNTER[12:8]};
					default:  BUS_RDATA <= 8'h00;
				endcase
			end
		end
	end

endmodule // cabx_exec

/* dv/cabx_exec_asserts.sv */
// Checker for the execute block, bound to its top module ports.
// Assumes single SYS_CLK domain and asynchronous active-low RST_N.
`timescale 1ns/1ps
module cabx_exec_asserts
	import cabx_pkg::*;
(
	// Clock and reset
	input wire logic          SYS_CLK,
	input wire logic          RST_N,
	// Instruction stream and software port
	input wire logic [13:0]   INSTR,
	input wire logic          INSTR_VALID,
	input wire logic          INSTR_READY,
	input wire cabx_bus_req_t BUS_REQ,
	// Core state
	input wire logic          PRESCALER_CLEAR,
	input wire logic [12:0]   PROGRAM_COUNTER,
	input wire logic [7:0]    W_REG,
	input wire logic [7:0]    STATUS_FLAGS
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	wire       tk  = INSTR_VALID && INSTR_READY;
	wire [5:0] o6  = INSTR[13:8];
	wire       bop = tk && INSTR[13:11] == 3'b010;
	wire       fwd = tk && o6 == OP_ADD_W_TO_FILE && INSTR[7];
	wire       pcw = (fwd || bop) && INSTR[6:0] == FA_PC_LOW;
	wire       fw1 = (fwd || bop) && INSTR[6:0] == FA_TIMER0_COUNT;
	wire [8:0] sum = {1'b0, W_REG} + {1'b0, INSTR[7:0]};
	wire [4:0] dsm = {1'b0, W_REG[3:0]} + {1'b0, INSTR[3:0]};
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_take_pcw; pcw; endsequence
	sequence s_nop; !INSTR_READY ##1 INSTR_READY; endsequence
	property p_two_cycle; s_take_pcw |=> s_nop; endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("no single nop cycle");
	property p_pc_step; tk && !pcw && !BUS_REQ.wr |=>
		PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 13'h0001; endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc not stepped");
	property p_xor; tk && o6 == OP_XOR_LITERAL |=> W_REG == ($past(W_REG) ^ $past(INSTR[7:0]))
		&& STATUS_FLAGS[ST_Z] == (W_REG == 8'h00) && $stable(STATUS_FLAGS[1:0]); endproperty
	a_xor: assert property (p_xor) else $error("xor result");
	property p_and; tk && o6 == OP_AND_LITERAL |=> W_REG == ($past(W_REG) & $past(INSTR[7:0]))
		&& STATUS_FLAGS[ST_Z] == (W_REG == 8'h00) && $stable(STATUS_FLAGS[1:0]); endproperty
	a_and: assert property (p_and) else $error("and result");
	property p_addl; tk && INSTR[13:9] == OP_ADD_LITERAL |=> W_REG == $past(sum[7:0])
		&& STATUS_FLAGS[2:0] == {W_REG == 8'h00, $past(dsm[4]), $past(sum[8])}; endproperty
	a_addl: assert property (p_addl) else $error("add literal result");
	property p_add_w_to_file_f; fwd |=> $stable(W_REG); endproperty
	a_add_w_to_file_f: assert property (p_add_w_to_file_f) else $error("w changed on file dest");
	property p_bit; bop && INSTR[6:0] != FA_STATUS |=>
		$stable(STATUS_FLAGS[2:0]) && $stable(W_REG); endproperty
	a_bit: assert property (p_bit) else $error("bit op touched flags");
	property p_psc; $rose(PRESCALER_CLEAR) |-> $past(fw1); endproperty
	a_psc: assert property (p_psc) else $error("stray prescaler clear");
endmodule // cabx_exec_asserts

bind cabx_exec cabx_exec_asserts u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .INSTR(INSTR),
	.INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .BUS_REQ(BUS_REQ),
	.PRESCALER_CLEAR(PRESCALER_CLEAR), .PROGRAM_COUNTER(PROGRAM_COUNTER),
	.W_REG(W_REG), .STATUS_FLAGS(STATUS_FLAGS));

/* dv/cabx_exec_bench.sv */
// Self-checking bench for the execute block through its instruction and software ports.
// Assumes the bench alone drives every input of the block.
`timescale 1ns/1ps
module cabx_exec_bench;
	import cabx_pkg::*;
	logic          sys_clk, rst_n, instr_valid, ready, psc, seen;
	logic [13:0]   instr;
	cabx_bus_req_t bus_req;
	logic [7:0]    rdata, w, st, d;
	logic [5:0]    pins, port_out;
	logic [12:0]   pc;
	logic [8:0]    s;
	logic [4:0]    h;
	int            err_total, checks_done;
	logic [7:0]    aw [4] = '{8'h0F, 8'hFF, 8'h80, 8'h12};
	logic [7:0]    ak [4] = '{8'h01, 8'h01, 8'h80, 8'h34};
	logic [7:0]    lk [4] = '{8'h5A, 8'hF0, 8'h0F, 8'h81};
	logic [7:0]    lw [4] = '{8'h5A, 8'h0F, 8'hF0, 8'hFF};
	logic [13:0]   pi [3] = '{{OP_BIT_SET, 3'h0, FA_TIMER0_COUNT},
		{OP_ADD_W_TO_FILE, 1'b0, FA_TIMER0_COUNT}, {OP_BIT_CLEAR, 3'h0, FA_TIMER0_COUNT}};
	logic [1:0]    pc_ctl [3] = '{2'b11, 2'b10, 2'b00};

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	cabx_exec u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .INSTR(instr), .INSTR_VALID(instr_valid),
		.INSTR_READY(ready), .BUS_REQ(bus_req), .BUS_RDATA(rdata), .PORT_PINS(pins),
		.PORT_OUT(port_out), .PRESCALER_CLEAR(psc), .PROGRAM_COUNTER(pc), .W_REG(w),
		.STATUS_FLAGS(st));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk) bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk) bus_req <= '0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk) bus_req <= '0;
		@(negedge sys_clk) d = rdata;
	endtask
	// Valid is left high so instructions can follow back to back
	task run(input logic [13:0] i);
		@(posedge sys_clk) instr <= i;
		instr_valid <= 1'b1;
	endtask
	task idle;
		@(posedge sys_clk) instr_valid <= 1'b0;
		@(negedge sys_clk);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	initial begin
		#(50 * 4000);
		err_total++;
		test_done;
	end

	initial begin
		rst_n = 1'b0; instr = '0; instr_valid = 1'b0; bus_req = '0; pins = 6'h2A;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(BA_W, aw[i]);
			run({OP_ADD_LITERAL, i[0], ak[i]}); idle;
			s = {1'b0, aw[i]} + {1'b0, ak[i]};
			h = {1'b0, aw[i][3:0]} + {1'b0, ak[i][3:0]};
			chk(w, s[7:0]);
			chk(st[2:0], {s[7:0] == 8'h00, h[4], s[8]});
		end
		$display("add literal done");
		wr({1'b0, FA_STATUS}, 8'h03);
		for (int i = 0; i < 4; i++) begin
			wr(BA_W, lw[i]);
			run({i < 2 ? OP_XOR_LITERAL : OP_AND_LITERAL, lk[i]}); idle;
			d = i < 2 ? lw[i] ^ lk[i] : lw[i] & lk[i];
			chk(w, d);
			chk(st[2:0], {d == 8'h00, 2'b11});
		end
		$display("logic literal done");
		wr(8'h20, 8'h70); wr(BA_W, 8'h90);
		run({OP_ADD_W_TO_FILE, 1'b0, 7'h20}); idle;
		chk(w, 8'h00); chk(st[2:0], 3'b101);
		rd(8'h20); chk(d, 8'h70);
		wr(BA_W, 8'h90);
		run({OP_ADD_W_TO_FILE, 1'b1, 7'h20}); idle;
		chk(w, 8'h90); rd(8'h20); chk(d, 8'h00);
		$display("add w to file done");
		wr({1'b0, FA_STATUS}, 8'h07); wr(8'h7F, 8'h00);
		for (int b = 0; b < 8; b++) run({OP_BIT_SET, b[2:0], 7'h7F});
		idle; rd(8'h7F); chk(d, 8'hFF);
		run({OP_BIT_CLEAR, 3'h7, 7'h7F}); run({OP_BIT_CLEAR, 3'h0, 7'h7F}); idle;
		rd(8'h7F); chk(d, 8'h7E); chk(st[2:0], 3'b111);
		$display("bit edit done");
		wr({1'b0, FA_PORT_A}, 8'h15); wr(BA_W, 8'h00);
		run({OP_ADD_W_TO_FILE, 1'b1, FA_PORT_A}); idle;
		chk(port_out, 6'h2A);
		@(posedge sys_clk) pins <= 6'h33;
		wr(BA_W, 8'h00); wr(BA_W, 8'h00);
		run({OP_BIT_CLEAR, 3'h1, FA_PORT_A}); idle;
		chk(port_out, 6'h31);
		$display("port read-modify-write done");
		// Timer register starts undefined; give it a value so W and flags stay known
		wr({1'b0, FA_TIMER0_COUNT}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(BA_CTRL, {7'h00, pc_ctl[i][1]});
			run(pi[i]); idle;
			seen = psc;
			@(negedge sys_clk) seen = seen | psc;
			chk(seen, pc_ctl[i][0]);
		end
		$display("prescaler clear done");
		wr(BA_PC_LO, 8'h40); wr(BA_PC_HI, 8'h00); wr(BA_W, 8'h10);
		run({OP_ADD_W_TO_FILE, 1'b1, FA_PC_LOW}); run({OP_XOR_LITERAL, 8'hFF});
		@(negedge sys_clk) chk(ready, 1'b0); chk(pc, 13'h0050);
		run({OP_XOR_LITERAL, 8'hFF}); idle;
		chk(w, 8'hEF); chk(pc, 13'h0051); chk(ready, 1'b1);
		rd(BA_W); chk(d, 8'hEF);
		rd(8'h90); chk(d, 8'h00);
		$display("program counter write done");
		test_done;
	end
endmodule // cabx_exec_bench
